// file: src/atov_params.svh
// Register offsets, field positions and timing constants for the activation test block.
`ifndef ATOV_PARAMS_SVH
`define ATOV_PARAMS_SVH
`define ATOV_ADDR_STATE     4'hB
`define ATOV_ADDR_TEST      4'hC
`define ATOV_ADDR_ECHO      4'hD
`define ATOV_BIT_TMR_DIS    0
`define ATOV_BIT_STEER      7
`define ATOV_BIT_INTERP     6
`define ATOV_BIT_LOAD       5
`define ATOV_BIT_STEP       4
`define ATOV_BIT_HOLD       3
`define ATOV_BIT_BIGJUMP    2
`define ATOV_BIT_RSVD       1
`define ATOV_BIT_FORCE      0
`define ATOV_BIT_MEC_UPD    7
`define ATOV_BIT_EC_ACC     6
`define ATOV_BIT_EC_UPD     5
`define ATOV_BIT_EC_FAST    4
`define ATOV_BIT_DFE_ACC    3
`define ATOV_BIT_DFE_UPD    2
`define ATOV_BIT_DFE_FAST   1
`define ATOV_BIT_CLR_COEF   0
`define ATOV_BYTE_ZERO      8'h00
`define ATOV_STATE_ZERO     7'h00
`define ATOV_STATE_ONE      7'h01
`define ATOV_STEP_BIG       3'h4
`define ATOV_STEP_SMALL     3'h1
`define ATOV_TMR_SECONDS    15
`define ATOV_CLK_HZ         100000000
`define ATOV_BAUD_CYCLES    12'h9C4
`define ATOV_TMR_ZERO       32'h0
`define ATOV_TMR_ONE        32'h1
`define ATOV_BAUD_ZERO      12'h000
`define ATOV_BAUD_ONE       12'h001
`endif

// file: src/atov_pkg.sv
// Types shared by the activation test and override register block.
package atov_pkg;
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [3:0] addr;
        logic [7:0] wdata;
    } atov_bus_type;

    typedef struct packed {
        logic       steer;
        logic       interp_en;
        logic       big_jump;
        logic [2:0] phase_step;
        logic       force_link;
        logic       mec_update;
        logic       ec_accumulate;
        logic       ec_update;
        logic       ec_fast;
        logic       dfe_accumulate;
        logic       dfe_update;
        logic       dfe_fast;
        logic       clear_coef;
        logic       baud_test_a;
        logic       baud_test_b;
    } atov_ctrl_type;

    typedef enum logic [1:0] {
        ATOV_ACT_IDLE,
        ATOV_ACT_WAIT_LOAD,
        ATOV_ACT_WAIT_STEP
    } atov_act_type;
endpackage

// file: src/atov_regs.sv
// Activation state, activation test and echo canceller test registers.
//
// Functional notes
// - Reset and soft reset clear all state.
// - Readback bit returns written control values.
// - Enabled timer expires after fifteen seconds.
// - Disabled timer clears to zero, expiry reads zero.
// - Bits 7:1 show state, top is warm.
// - Test register reads indicator bits 18:11.
// - Echo register reads indicator bits 10:3.
// - Overlay selects hide test and echo registers.
// - Steer bit hands echo, interpolator and baud test control to override bits.
// - Interpolator follows bit only in termination mode.
// - Rising load bit adopts state within one baud.
// - Load and step override the hold.
// - Step advances once when continuation allowed.
// - Hold freezes state until load or step.
// - Phase steps are four or one units.
// - Force-link presents full-duplex transparent status.
// - Echo bits act only under steer.
// - Zero update bits freeze coefficients.
// - Equalizer accumulate zero forces alternating symbols.
// - Fast bits select fastest adaptation rate.
// - Clear zeroes coefficients, resets elastic buffer.
`timescale 1ns/10ps
`include "atov_params.svh"

module atov_regs #(
    parameter int unsigned TIMER_CYCLES = `ATOV_TMR_SECONDS * `ATOV_CLK_HZ
) (
    input  wire logic                   clk,              // System clock, 100 MHz.
    input  wire logic                   sys_rst,          // Synchronous reset, active high.
    input  wire logic                   soft_rst,         // Software reset command pulse.
    input  wire atov_pkg::atov_bus_type bus,              // Control port access.
    output logic [7:0]                  rdata,            // Read data, registered.
    input  wire logic                   diag_readback,    // Readback of written controls.
    input  wire logic                   sel_dch_access,   // Data channel overlay select.
    input  wire logic                   sel_dump_access,  // Dump/restore overlay select.
    input  wire logic [7:0]             dch_rdata,        // Data channel port read value.
    input  wire logic [7:0]             dump_rdata,       // Dump/restore port read value.
    input  wire logic [15:0]            epi_value,        // Indicator bits 18:3.
    input  wire logic                   frame_strobe,     // Once per frame.
    input  wire logic                   baud_strobe,      // Once per baud.
    input  wire logic                   activating,       // Activation in progress.
    input  wire logic                   continue_ok,      // Step condition met.
    input  wire logic [6:0]             next_state,       // Controller's next state.
    input  wire logic                   lt_mode,          // Line termination mode.
    input  wire logic                   baud_test_a_in,   // Baud clock test bit a.
    input  wire logic                   baud_test_b_in,   // Baud clock test bit b.
    output logic [6:0]                  act_state,        // Current activation state.
    output logic                        timer_expired,    // Activation timer expiry.
    output atov_pkg::atov_ctrl_type     ctrl,             // Steered control outputs.
    output logic                        dch_wr,           // Write to data channel port.
    output logic                        dump_wr           // Write to dump/restore port.
);
    import atov_pkg::*;

    logic [7:0]   state_ctl_reg;
    logic [7:0]   test_ctl_reg;
    logic [7:0]   echo_ctl_reg;
    logic [15:0]  epi_reg;
    logic [6:0]   state_reg;
    logic [31:0]  timer_reg;
    logic         expired_reg;
    logic         load_prev_reg;
    logic         step_prev_reg;
    logic [11:0]  baud_cnt_reg;
    atov_act_type act_reg;
    atov_ctrl_type ctrl_reg;
    logic         clr;
    logic         steer;
    logic [7:0]   state_read;

    assign clr   = sys_rst | soft_rst;
    assign steer = test_ctl_reg[`ATOV_BIT_STEER];

    // ==================================================================
    // Register writes
    always_ff @(posedge clk) begin
        if (clr) begin
            state_ctl_reg <= `ATOV_BYTE_ZERO;
            test_ctl_reg  <= `ATOV_BYTE_ZERO;
            echo_ctl_reg  <= `ATOV_BYTE_ZERO;
        end else if (bus.wr_en) begin
            if (bus.addr == `ATOV_ADDR_STATE) begin
                state_ctl_reg <= bus.wdata;
            end
            if (bus.addr == `ATOV_ADDR_TEST && !sel_dch_access) begin
                test_ctl_reg <= bus.wdata;
            end
            if (bus.addr == `ATOV_ADDR_ECHO && !sel_dump_access) begin
                echo_ctl_reg <= bus.wdata;
            end
        end
    end

    assign dch_wr  = bus.wr_en && bus.addr == `ATOV_ADDR_TEST && sel_dch_access;
    assign dump_wr = bus.wr_en && bus.addr == `ATOV_ADDR_ECHO && sel_dump_access;

    // ==================================================================
    // Error power indicator, refreshed once per frame
    always_ff @(posedge clk) begin
        if (clr) begin
            epi_reg <= 16'h0000;
        end else if (frame_strobe) begin
            epi_reg <= epi_value;
        end
    end

    // ==================================================================
    // Activation timer
    always_ff @(posedge clk) begin
        if (clr || state_ctl_reg[`ATOV_BIT_TMR_DIS] || !activating) begin
            timer_reg   <= `ATOV_TMR_ZERO;
            expired_reg <= 1'b0;
        end else if (timer_reg >= TIMER_CYCLES - `ATOV_TMR_ONE) begin
            expired_reg <= 1'b1;
        end else begin
            timer_reg <= timer_reg + `ATOV_TMR_ONE;
        end
    end

    assign timer_expired = expired_reg & ~state_ctl_reg[`ATOV_BIT_TMR_DIS];

    // ==================================================================
    // Baud deadline for loads: adopt at the baud strobe or at the limit
    always_ff @(posedge clk) begin
        if (clr || act_reg != ATOV_ACT_WAIT_LOAD) begin
            baud_cnt_reg <= `ATOV_BAUD_ZERO;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + `ATOV_BAUD_ONE;
        end
    end

    // ==================================================================
    // Activation controller state
    always_ff @(posedge clk) begin
        if (clr) begin
            state_reg     <= `ATOV_STATE_ZERO;
            act_reg       <= ATOV_ACT_IDLE;
            load_prev_reg <= 1'b0;
            step_prev_reg <= 1'b0;
        end else begin
            load_prev_reg <= test_ctl_reg[`ATOV_BIT_LOAD];
            step_prev_reg <= test_ctl_reg[`ATOV_BIT_STEP];
            case (act_reg)
                ATOV_ACT_IDLE: begin
                    if (test_ctl_reg[`ATOV_BIT_LOAD] && !load_prev_reg) begin
                        act_reg <= ATOV_ACT_WAIT_LOAD;
                    end else if (test_ctl_reg[`ATOV_BIT_STEP] && !step_prev_reg) begin
                        act_reg <= ATOV_ACT_WAIT_STEP;
                    end else if (!test_ctl_reg[`ATOV_BIT_HOLD] && baud_strobe) begin
                        state_reg <= next_state;
                    end
                end
                ATOV_ACT_WAIT_LOAD: begin
                    if (baud_strobe || baud_cnt_reg >= `ATOV_BAUD_CYCLES - `ATOV_BAUD_ONE) begin
                        state_reg <= state_ctl_reg[7:1];
                        act_reg   <= ATOV_ACT_IDLE;
                    end
                end
                ATOV_ACT_WAIT_STEP: begin
                    if (!test_ctl_reg[`ATOV_BIT_STEP]) begin
                        act_reg <= ATOV_ACT_IDLE;
                    end else if (continue_ok && baud_strobe) begin
                        state_reg <= next_state;
                        act_reg   <= ATOV_ACT_IDLE;
                    end
                end
                default: begin
                    act_reg <= ATOV_ACT_IDLE;
                end
            endcase
        end
    end

    assign act_state = state_reg;

    // ==================================================================
    // Steered control outputs
    always_ff @(posedge clk) begin
        if (clr) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg.steer      <= steer;
            ctrl_reg.interp_en  <= steer && lt_mode && test_ctl_reg[`ATOV_BIT_INTERP];
            ctrl_reg.big_jump   <= test_ctl_reg[`ATOV_BIT_BIGJUMP];
            ctrl_reg.phase_step <= test_ctl_reg[`ATOV_BIT_BIGJUMP] ?
                                   `ATOV_STEP_BIG : `ATOV_STEP_SMALL;
            ctrl_reg.force_link <= test_ctl_reg[`ATOV_BIT_FORCE];
            // Without steer the processor runs normally: updates on, outputs summed.
            ctrl_reg.mec_update     <= !steer || echo_ctl_reg[`ATOV_BIT_MEC_UPD];
            ctrl_reg.ec_accumulate  <= !steer || echo_ctl_reg[`ATOV_BIT_EC_ACC];
            ctrl_reg.ec_update      <= !steer || echo_ctl_reg[`ATOV_BIT_EC_UPD];
            ctrl_reg.ec_fast        <= steer && echo_ctl_reg[`ATOV_BIT_EC_FAST];
            ctrl_reg.dfe_accumulate <= !steer || echo_ctl_reg[`ATOV_BIT_DFE_ACC];
            ctrl_reg.dfe_update     <= !steer || echo_ctl_reg[`ATOV_BIT_DFE_UPD];
            ctrl_reg.dfe_fast       <= steer && echo_ctl_reg[`ATOV_BIT_DFE_FAST];
            ctrl_reg.clear_coef     <= steer && echo_ctl_reg[`ATOV_BIT_CLR_COEF];
            ctrl_reg.baud_test_a    <= steer && baud_test_a_in;
            ctrl_reg.baud_test_b    <= steer && baud_test_b_in;
        end
    end

    assign ctrl = ctrl_reg;

    // ==================================================================
    // Read path
    assign state_read = {state_reg, timer_expired};

    always_ff @(posedge clk) begin
        if (clr) begin
            rdata <= `ATOV_BYTE_ZERO;
        end else if (bus.rd_en) begin
            case (bus.addr)
                `ATOV_ADDR_STATE: rdata <= diag_readback ? state_ctl_reg : state_read;
                `ATOV_ADDR_TEST:  rdata <= sel_dch_access ? dch_rdata :
                                           diag_readback ? test_ctl_reg : epi_reg[15:8];
                `ATOV_ADDR_ECHO:  rdata <= sel_dump_access ? dump_rdata :
                                           diag_readback ? echo_ctl_reg : epi_reg[7:0];
                default:          rdata <= `ATOV_BYTE_ZERO;
            endcase
        end
    end
endmodule

// file: tb/atov_cpu_model.sv
// Model of the internal processor: baud and frame timing, indicator and next state.
`timescale 1ns/10ps
module atov_cpu_model #(
    parameter int BAUD = 16
) (
    input  wire logic       clk,          // Clock.
    input  wire logic       sys_rst,      // Reset.
    input  wire logic [6:0] act_state,    // Current state.
    output logic            baud_strobe,  // One pulse per baud.
    output logic            frame_strobe, // One pulse per four bauds.
    output logic [15:0]     epi_value,    // Indicator, new each frame.
    output logic [6:0]      next_state    // Successor state.
);
    int cnt = 0;
    int seed = 32'h5A17;
    assign next_state = act_state + 7'h03;
    initial {baud_strobe, frame_strobe, epi_value} = '0;
    always @(posedge clk) begin
        cnt <= (sys_rst || cnt == 4 * BAUD - 1) ? 0 : cnt + 1;
        baud_strobe <= !sys_rst && cnt % BAUD == 0;
        frame_strobe <= !sys_rst && cnt == 0;
        if (!sys_rst && cnt == 0) epi_value <= 16'($random(seed));
    end
endmodule

// file: tb/atov_regs_bench.sv
// Self-checking bench for the activation test register block.
`timescale 1ns/10ps
`include "atov_params.svh"
module atov_regs_bench;
    import atov_pkg::*;
    localparam int TMR = 100;
    localparam int BAUD = 16;
    logic clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, diag_readback = 1'b0;
    logic sel_dch_access = 1'b0, sel_dump_access = 1'b0, activating = 1'b0, continue_ok = 1'b0;
    logic lt_mode = 1'b0, baud_test_a_in = 1'b0, baud_test_b_in = 1'b0, timer_expired;
    logic [7:0] dch_rdata = 8'h00, dump_rdata = 8'h00, rdata;
    logic baud_strobe, frame_strobe, dch_wr, dump_wr;
    logic [15:0] epi_value;
    logic [6:0] next_state, act_state;
    atov_bus_type bus = '0;
    atov_ctrl_type ctrl;
    int n_mismatch = 0, n_tests = 0, seed = 32'hda3e;
    always #5 clk = ~clk;
    atov_regs #(.TIMER_CYCLES(TMR)) i_atov_regs (.clk, .sys_rst, .soft_rst, .bus, .rdata,
        .diag_readback, .sel_dch_access, .sel_dump_access, .dch_rdata, .dump_rdata, .epi_value,
        .frame_strobe, .baud_strobe, .activating, .continue_ok, .next_state, .lt_mode,
        .baud_test_a_in, .baud_test_b_in, .act_state, .timer_expired, .ctrl, .dch_wr, .dump_wr);
    atov_cpu_model #(.BAUD(BAUD)) i_atov_cpu_model (.clk, .sys_rst, .act_state, .baud_strobe,
        .frame_strobe, .epi_value, .next_state);
    function automatic logic [7:0] echo_exp(logic steer, logic [7:0] r);
        return steer ? r : 8'hEC;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk) bus <= {2'b10, a, d};
        @(posedge clk) bus <= '0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
        @(posedge clk) bus <= {2'b01, a, 8'h00};
        @(posedge clk) bus <= '0;
        #1 chk(what, rdata, exp);
    endtask
    task automatic wait_state(logic [6:0] s);
        for (int i = 0; i < BAUD + 4 && act_state !== s; i++) @(negedge clk);
        chk("act_state", {1'b0, act_state}, {1'b0, s});
        if (act_state !== s) wrap_up();
    endtask
    initial begin
        logic [7:0] r;
        int n;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ATOV_ADDR_STATE, 8'h00, "state after reset");
        rd(4'h3, 8'h00, "unmapped");
        r = $random(seed);
        wr(`ATOV_ADDR_TEST, 8'h08);
        wr(`ATOV_ADDR_STATE, {r[7:1], 1'b0});
        wr(`ATOV_ADDR_TEST, 8'h28);
        wait_state(r[7:1]);
        repeat (3 * BAUD) @(negedge clk);
        chk("held", {1'b0, act_state}, {1'b0, r[7:1]});
        wr(`ATOV_ADDR_TEST, 8'h18);
        repeat (2 * BAUD) @(negedge clk);
        chk("step blocked", {1'b0, act_state}, {1'b0, r[7:1]});
        continue_ok <= 1'b1;
        wait_state(r[7:1] + 7'h03);
        repeat (3 * BAUD) @(negedge clk);
        rd(`ATOV_ADDR_STATE, {r[7:1] + 7'h03, 1'b0}, "one step");
        diag_readback <= 1'b1;
        rd(`ATOV_ADDR_STATE, {r[7:1], 1'b0}, "readback state");
        rd(`ATOV_ADDR_TEST, 8'h18, "readback test");
        diag_readback <= 1'b0;
        activating <= 1'b1;
        for (n = 0; n < 2 * TMR && timer_expired !== 1'b1; n++) @(negedge clk);
        chk("timer span", {7'h00, n >= TMR - 4 && n <= TMR + 4}, 8'h01);
        if (timer_expired !== 1'b1) wrap_up();
        wr(`ATOV_ADDR_STATE, 8'h01);
        @(negedge clk);
        chk("expiry masked", {7'h00, timer_expired}, 8'h00);
        for (n = 0; n < 8 * BAUD && frame_strobe !== 1'b1; n++) @(negedge clk);
        chk("frame seen", {7'h00, frame_strobe}, 8'h01);
        if (frame_strobe !== 1'b1) wrap_up();
        @(negedge clk);
        rd(`ATOV_ADDR_TEST, epi_value[15:8], "indicator high");
        rd(`ATOV_ADDR_ECHO, epi_value[7:0], "indicator low");
        sel_dch_access <= 1'b1;
        sel_dump_access <= 1'b1;
        dch_rdata <= $random(seed);
        dump_rdata <= $random(seed);
        @(negedge clk);
        rd(`ATOV_ADDR_TEST, dch_rdata, "data channel");
        rd(`ATOV_ADDR_ECHO, dump_rdata, "dump port");
        wr(`ATOV_ADDR_TEST, 8'h55);
        sel_dch_access <= 1'b0;
        sel_dump_access <= 1'b0;
        repeat (2) @(negedge clk);
        chk("overlay kept", {7'h00, ctrl.force_link}, 8'h00);
        lt_mode <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            r = $random(seed);
            baud_test_a_in <= r[0];
            baud_test_b_in <= r[1];
            wr(`ATOV_ADDR_ECHO, r);
            wr(`ATOV_ADDR_TEST, {k[0], 4'b1001, k[1], 2'b01});
            repeat (2) @(negedge clk);
            chk("echo ctrl", ctrl[9:2], echo_exp(k[0], r));
            chk("phase step", {5'h00, ctrl.phase_step}, k[1] ? 8'h04 : 8'h01);
            chk("interp", {7'h00, ctrl.interp_en}, {7'h00, k[0]});
            chk("force link", {7'h00, ctrl.force_link}, 8'h01);
            chk("steer", {7'h00, ctrl.steer}, {7'h00, k[0]});
            if (k[0]) chk("baud test", {6'h00, ctrl.baud_test_a, ctrl.baud_test_b}, {6'h00, r[0], r[1]});
        end
        @(posedge clk) soft_rst <= 1'b1;
        @(posedge clk) soft_rst <= 1'b0;
        @(negedge clk);
        chk("soft reset", {act_state, timer_expired}, 8'h00);
        diag_readback <= 1'b1;
        rd(`ATOV_ADDR_TEST, 8'h00, "test cleared");
        wrap_up();
    end
endmodule

// file: tb/atov_regs_props.sv
// Concurrent checks on the ports of the activation test register block.
`timescale 1ns/10ps
`include "atov_params.svh"
module atov_regs_props #(
    parameter int unsigned TIMER_CYCLES = 100
) (
    input wire logic                    clk,             // Clock.
    input wire logic                    sys_rst,         // Reset.
    input wire logic                    soft_rst,        // Soft reset.
    input wire atov_pkg::atov_bus_type  bus,             // Access.
    input wire logic [7:0]              rdata,           // Read data.
    input wire logic                    diag_readback,   // Readback mode.
    input wire logic                    sel_dch_access,  // Overlay on test address.
    input wire logic                    sel_dump_access, // Overlay on echo address.
    input wire logic [15:0]             epi_value,       // Indicator.
    input wire logic                    frame_strobe,    // Frame pulse.
    input wire logic [6:0]              act_state,       // State.
    input wire logic                    timer_expired,   // Expiry.
    input wire atov_pkg::atov_ctrl_type ctrl,            // Controls.
    input wire logic                    dch_wr           // Overlay write.
);
    import atov_pkg::*;
    logic        tmr_dis_q;
    logic [15:0] epi_q;
    wire         clr = sys_rst || soft_rst;
    wire         rd_ok = bus.rd_en && !diag_readback;
    always_ff @(posedge clk) begin
        if (clr) tmr_dis_q <= 1'b0;
        else if (bus.wr_en && bus.addr == `ATOV_ADDR_STATE) tmr_dis_q <= bus.wdata[0];
    end
    always_ff @(posedge clk) begin
        if (clr) epi_q <= 16'h0000;
        else if (frame_strobe) epi_q <= epi_value;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_overlay_write: assert property (
        bus.wr_en && bus.addr == `ATOV_ADDR_TEST && sel_dch_access |-> dch_wr)
        else $error("Overlay write not routed.");
    a_timer_off_zero: assert property (tmr_dis_q && $past(tmr_dis_q) |-> !timer_expired)
        else $error("Expiry seen with timer disabled.");
    a_epi_high_read: assert property (
        rd_ok && bus.addr == `ATOV_ADDR_TEST && !sel_dch_access && !frame_strobe
        |=> rdata == epi_q[15:8]) else $error("Indicator high byte wrong.");
    a_epi_low_read: assert property (
        rd_ok && bus.addr == `ATOV_ADDR_ECHO && !sel_dump_access && !frame_strobe
        |=> rdata == epi_q[7:0]) else $error("Indicator low byte wrong.");
    a_state_read_back: assert property (
        rd_ok && bus.addr == `ATOV_ADDR_STATE |=> rdata == {$past(act_state), $past(timer_expired)})
        else $error("State read wrong.");
    a_soft_reset_clear: assert property (
        soft_rst |=> act_state == 7'h00 && !timer_expired && rdata == 8'h00)
        else $error("Soft reset left state.");
    a_phase_step_size: assert property (
        !$past(clr) |-> ctrl.phase_step == (ctrl.big_jump ? 3'h4 : 3'h1))
        else $error("Phase step size wrong.");
    a_echo_needs_steer: assert property (!$past(clr) && !ctrl.steer |-> ctrl[9:2] == 8'hEC)
        else $error("Echo controls active without steer.");
    c_overlay: cover property (dch_wr);
    c_expiry: cover property ($rose(timer_expired));
    c_steer: cover property (ctrl.steer && ctrl.force_link);
endmodule
bind atov_regs atov_regs_props #(.TIMER_CYCLES(TIMER_CYCLES)) i_atov_regs_props (.clk, .sys_rst,
    .soft_rst, .bus, .rdata, .diag_readback, .sel_dch_access, .sel_dump_access, .epi_value,
    .frame_strobe, .act_state, .timer_expired, .ctrl, .dch_wr);
